//--- cipher_key_count_crc_regs.vh
`ifndef CIPHER_KEY_COUNT_CRC_REGS_VH
`define CIPHER_KEY_COUNT_CRC_REGS_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IDX_CIPHER_CONTROL        8'h01
`define IDX_CIPHER_START_ADDRESS  8'h02
`define IDX_CIPHER_BLOCK_COUNT    8'h03
`define IDX_CIPHER_KEY_PORT       8'h04
`define IDX_CRC_RESULT_PORT       8'h05

// ****************************************
// Field positions and widths
// ****************************************
`define CTRL_START_BIT            0
`define CTRL_CRC_ENABLE_BIT       1
`define CTRL_ENCRYPT_BIT          2
`define CTRL_BUSY_BIT             3
`define BLOCK_COUNT_WIDTH         13
`define BLOCK_BYTES               8

// ****************************************
// Reset values
// ****************************************
`define RST_CIPHER_CONTROL        3'h0
`define RST_CIPHER_START_ADDRESS  16'h0000
`define RST_CIPHER_BLOCK_COUNT    13'h0000
`define RST_CIPHER_KEY            64'h0000000000000000
`define RST_CRC                   32'h00000000
`define CRC_POLY                  32'h04C11DB7

`endif

//--- cipher_key_count_crc_regs.v
// The AHB-Lite slave port is this design's own decision.
`include "cipher_key_count_crc_regs.vh"

module cipher_key_count_crc_regs (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [2:0]  hburst,
  input  wire [3:0]  hprot,
  input  wire        hmastlock,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        engine_busy,
  input  wire        crc_word_valid,
  input  wire [15:0] crc_word,
  output reg         cipher_start,
  output reg         cipher_crc_enable,
  output reg         cipher_encrypt,
  output reg  [15:0] cipher_start_address,
  output reg  [12:0] cipher_block_count,
  output reg  [63:0] cipher_key,
  output wire [31:0] crc_value
);

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] crc_step;
    input [31:0] crc;
    input [15:0] data;
    integer i;
    reg [31:0] c;
    begin
      c = crc;
      for (i = 15; i >= 0; i = i - 1) begin
        if (c[31] ^ data[i]) begin
          c = {c[30:0], 1'b0} ^ `CRC_POLY;
        end else begin
          c = {c[30:0], 1'b0};
        end
      end
      crc_step = c;
    end
  endfunction

  function [15:0] key_word;
    input [63:0] key;
    input [1:0]  sel;
    begin
      case (sel)
        2'd0:    key_word = key[15:0];
        2'd1:    key_word = key[31:16];
        2'd2:    key_word = key[47:32];
        default: key_word = key[63:48];
      endcase
    end
  endfunction

  // ****************************************
  // Bus state
  // ****************************************
  reg  [31:0] crc_lfsr;
  reg         crc_read_high;
  reg  [1:0]  key_write_ptr;
  reg         wr_pending;
  reg  [7:0]  wr_index;
  reg  [31:0] next_hrdata;
  reg  [7:0]  next_rd_index;

  wire        addr_phase = hsel & hready & htrans[1];
  wire        rd_take    = addr_phase & ~hwrite & ce;
  wire        wr_take    = addr_phase & hwrite & ce;
  wire [7:0]  index      = haddr[9:2];
  wire        start_req  = ce & wr_pending & (wr_index == `IDX_CIPHER_CONTROL)
                           & hwdata[`CTRL_START_BIT];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign crc_value = crc_lfsr;

  // ****************************************
  // Read data mux
  // ****************************************
  always @* begin
    next_rd_index = index;
    next_hrdata   = 32'h00000000;
    if (next_rd_index == `IDX_CIPHER_CONTROL) begin
      next_hrdata[`CTRL_CRC_ENABLE_BIT] = cipher_crc_enable;
      next_hrdata[`CTRL_ENCRYPT_BIT]    = cipher_encrypt;
      next_hrdata[`CTRL_BUSY_BIT]       = engine_busy;
    end else if (next_rd_index == `IDX_CIPHER_START_ADDRESS) begin
      next_hrdata[15:0] = cipher_start_address;
    end else if (next_rd_index == `IDX_CIPHER_BLOCK_COUNT) begin
      next_hrdata[12:0] = cipher_block_count;
    end else if (next_rd_index == `IDX_CIPHER_KEY_PORT) begin
      next_hrdata[15:0] = key_word(cipher_key, key_write_ptr);
    end else if (next_rd_index == `IDX_CRC_RESULT_PORT) begin
      next_hrdata[15:0] = crc_read_high ? crc_lfsr[31:16] : crc_lfsr[15:0];
    end
  end

  // ****************************************
  // Bus phases and read pointer
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending    <= 1'b0;
      wr_index      <= 8'h00;
      hrdata        <= 32'h00000000;
      crc_read_high <= 1'b0;
    end else if (ce) begin
      if (hready) begin
        wr_pending <= wr_take;
        wr_index   <= index;
      end
      if (rd_take) begin
        hrdata <= next_hrdata;
      end
      if (start_req) begin
        crc_read_high <= 1'b0;
      end else if (rd_take && index == `IDX_CRC_RESULT_PORT) begin
        crc_read_high <= ~crc_read_high;
      end
    end
  end

  // ****************************************
  // Control, address, count and key
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cipher_start         <= 1'b0;
      {cipher_encrypt, cipher_crc_enable} <= 2'b00;
      cipher_start_address <= `RST_CIPHER_START_ADDRESS;
      cipher_block_count   <= `RST_CIPHER_BLOCK_COUNT;
      cipher_key           <= `RST_CIPHER_KEY;
      key_write_ptr        <= 2'd0;
    end else if (ce) begin
      cipher_start <= start_req;
      if (wr_pending) begin
        if (wr_index == `IDX_CIPHER_CONTROL) begin
          cipher_crc_enable <= hwdata[`CTRL_CRC_ENABLE_BIT];
          cipher_encrypt    <= hwdata[`CTRL_ENCRYPT_BIT];
        end else if (wr_index == `IDX_CIPHER_START_ADDRESS) begin
          cipher_start_address <= hwdata[15:0];
        end else if (wr_index == `IDX_CIPHER_BLOCK_COUNT) begin
          cipher_block_count <= hwdata[`BLOCK_COUNT_WIDTH-1:0];
        end else if (wr_index == `IDX_CIPHER_KEY_PORT) begin
          case (key_write_ptr)
            2'd0:    cipher_key[15:0]  <= hwdata[15:0];
            2'd1:    cipher_key[31:16] <= hwdata[15:0];
            2'd2:    cipher_key[47:32] <= hwdata[15:0];
            default: cipher_key[63:48] <= hwdata[15:0];
          endcase
          key_write_ptr <= key_write_ptr + 2'd1;
        end
      end
    end
  end

  // ****************************************
  // CRC shift register
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_lfsr <= `RST_CRC;
    end else if (ce) begin
      if (start_req) begin
        crc_lfsr <= `RST_CRC;
      end else if (crc_word_valid) begin
        crc_lfsr <= crc_step(crc_lfsr, crc_word);
      end
    end
  end
  // Only start and CRC words move the CRC

endmodule // cipher_key_count_crc_regs

//--- cipher_regs_chk.sv
`include "cipher_key_count_crc_regs.vh"
module cipher_regs_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        ce,
  input wire        hwrite,
  input wire        hreadyout,
  input wire        hresp,
  input wire        crc_word_valid,
  input wire        cipher_start,
  input wire [1:0]  htrans,
  input wire [31:0] haddr,
  input wire [31:0] hwdata,
  input wire [31:0] crc_value,
  input wire [63:0] cipher_key
);
  wire tk = ce && hreadyout && htrans[1] && hwrite;
  wire kq = tk && haddr[9:2] == `IDX_CIPHER_KEY_PORT;
  wire cq = tk && haddr[9:2] == `IDX_CIPHER_CONTROL;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_ok_a: assert property (hreadyout && !hresp)
    else $error("bad answer");
  key_rst_a: assert property (disable iff (1'h0) !hresetn |-> cipher_key == 64'h0)
    else $error("key rst");
  crc_rst_a: assert property (disable iff (1'h0) !hresetn |-> crc_value == 32'h0)
    else $error("crc rst");
  crc_seed_a: assert property (cipher_start |-> crc_value == 32'h0)
    else $error("crc seed");
  crc_hold_a: assert property ($changed(crc_value) |->
    $past(crc_word_valid) || cipher_start) else $error("crc moved");
  key_src_a: assert property ($changed(cipher_key) |-> $past(kq, 2))
    else $error("key moved");
  start_src_a: assert property (cipher_start |-> $past(cq, 2) && $past(hwdata[0]))
    else $error("stray start");
  start_go_a: assert property ($past(cq) && hwdata[0] && ce |=> cipher_start)
    else $error("no start");
  cover property (cipher_start);
  cover property (kq);
  cover property (crc_word_valid);
endmodule // cipher_regs_chk
bind cipher_key_count_crc_regs cipher_regs_chk i_cipher_regs_chk (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans), .haddr(haddr),
  .hwdata(hwdata), .crc_word_valid(crc_word_valid), .cipher_start(cipher_start),
  .crc_value(crc_value), .cipher_key(cipher_key));

//--- cipher_key_count_crc_regs_tb.sv
`include "cipher_key_count_crc_regs.vh"
module cipher_key_count_crc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'h0, hresetn, hwrite = 1'h0, vld = 1'h0, hreadyout, hresp;
  logic [15:0] sa;
  logic [1:0]  htrans = 2'h0;
  logic [15:0] cw = 16'h0;
  logic [12:0] cnt;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, crc, r, d, mc = 32'h0;
  logic [63:0] key, mk = 64'h0;
  int          err_count = 0, n_compared = 0, kp = 0;
  cipher_key_count_crc_regs i_cipher_key_count_crc_regs (.hclk(hclk), .hresetn(hresetn),
    .ce(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hburst(3'h0), .hprot(4'h0), .hmastlock(1'h0), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .engine_busy(vld),
    .crc_word_valid(vld), .crc_word(cw), .cipher_start(), .cipher_crc_enable(),
    .cipher_encrypt(), .cipher_start_address(sa), .cipher_block_count(cnt), .cipher_key(key),
    .crc_value(crc));
  task automatic chk(input logic [63:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] v);
    htrans <= 2'h2;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #50 hclk = ~hclk;
  initial begin
    #100000 err_count++;
    finish_test;
  end
  initial begin
    hresetn <= 1'h0;
    r = $urandom(7);
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, `IDX_CIPHER_KEY_PORT, 32'h0);
    chk(r, 64'h0);
    repeat (5) begin
      d = $urandom;
      bus(1'h1, `IDX_CIPHER_KEY_PORT, d);
      mk[16*kp +: 16] = d[15:0];
      kp = (kp + 1) % 4;
      @(posedge hclk);
      chk(key, mk);
    end
    bus(1'h1, `IDX_CIPHER_BLOCK_COUNT, d);
    @(posedge hclk);
    chk(cnt, d[12:0]);
    bus(1'h1, `IDX_CIPHER_START_ADDRESS, d);
    @(posedge hclk);
    chk(sa, d[15:0]);
    // Second pass starts after an odd read, so the pointer must come back low
    repeat (2) begin
      bus(1'h1, `IDX_CRC_RESULT_PORT, d);
      repeat (7) begin
        d = $urandom;
        vld <= d[16];
        cw <= d[15:0];
        if (d[16]) for (int b = 15; b >= 0; b--)
          mc = {mc[30:0], 1'h0} ^ ((mc[31] ^ d[b]) ? `CRC_POLY : 32'h0);
        @(posedge hclk);
      end
      vld <= 1'h0;
      for (kp = 0; kp < 3; kp++) begin
        bus(1'h0, `IDX_CRC_RESULT_PORT, d);
        chk(r, kp[0] ? mc[31:16] : mc[15:0]);
      end
      bus(1'h1, `IDX_CIPHER_CONTROL, 32'h1);
      @(posedge hclk);
      chk(crc, 64'h0);
      mc = 32'h0;
    end
    // Control read back with the busy input raised
    vld <= 1'h1;
    bus(1'h1, `IDX_CIPHER_CONTROL, 32'h6);
    @(posedge hclk);
    bus(1'h0, `IDX_CIPHER_CONTROL, 32'h0);
    chk(r, 64'hE);
    vld <= 1'h0;
    // Reset in mid-run clears the key and its write pointer
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk(key, 64'h0);
    d = $urandom;
    bus(1'h1, `IDX_CIPHER_KEY_PORT, d);
    @(posedge hclk);
    chk(key, {48'h0, d[15:0]});
    finish_test;
  end
endmodule // cipher_key_count_crc_regs_tb
